/* pkg/srs_pkg.sv */
// Constants, register map and state type of the system reset sequencer
package srs_pkg;
    // Register offsets
    localparam logic [3:0] SRS_ADDR_DBGCTL = 4'h0;
    localparam logic [3:0] SRS_ADDR_CFG = 4'h1;
    localparam logic [3:0] SRS_ADDR_CAUSE = 4'h2;
    localparam logic [3:0] SRS_ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] SRS_ADDR_IRQ_MASK = 4'h4;
    // Field positions
    localparam int SRS_DBGCTL_RST_BIT = 0;
    localparam int SRS_CFG_WDT_RST_BIT = 0;
    localparam int SRS_CAUSE_POR_BIT = 7;
    localparam int SRS_CAUSE_BO_BIT = 6;
    localparam int SRS_CAUSE_WDT_BIT = 5;
    localparam int SRS_CAUSE_PIN_BIT = 4;
    localparam int SRS_CAUSE_DBGREQ_BIT = 3;
    localparam int SRS_CAUSE_STOPPIN_BIT = 2;
    localparam int SRS_CAUSE_DBGPIN_BIT = 1;
    localparam int SRS_IRQ_WDT_BIT = 0;
    localparam int SRS_IRQ_GLITCH_BIT = 1;
    localparam int SRS_IRQ_RELEASE_BIT = 2;
    // Reset values
    localparam logic [7:0] SRS_CFG_RST = 8'h01;
    localparam logic [7:0] SRS_MASK_RST = 8'h00;
    localparam logic [7:0] SRS_ZERO = 8'h00;
    // Timing
    localparam int SRS_CLK_MHZ = 250;
    localparam int SRS_POR_TIME_NS = 20000;
    localparam int SRS_POR_XTAL_TIME_NS = 400000;
    localparam int SRS_SYS_RST_TIME_NS = 40;
    localparam int SRS_POR_CYCLES = (SRS_POR_TIME_NS * SRS_CLK_MHZ + 999) / 1000;
    localparam int SRS_POR_XTAL_CYCLES = (SRS_POR_XTAL_TIME_NS * SRS_CLK_MHZ + 999) / 1000;
    localparam int SRS_SYS_RST_CYCLES = (SRS_SYS_RST_TIME_NS * SRS_CLK_MHZ + 999) / 1000;
    localparam int SRS_PIN_MIN_CYCLES = 3;
    // Sequencer states
    typedef enum logic [3:0] {
        SRS_ST_HOLD = 4'b0001,
        SRS_ST_POR = 4'b0010,
        SRS_ST_SYS = 4'b0100,
        SRS_ST_RUN = 4'b1000
    } srs_state_type;
endpackage

/* verilog/srs_pin_filter.sv */
// Reset pin synchroniser and minimum-width filter
`timescale 1ns/1ps
module srs_pin_filter #(
    parameter int MIN_CYCLES = srs_pkg::SRS_PIN_MIN_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Pin and control
    input wire logic pin_b_i,
    input wire logic enable_i,
    // Results
    output logic req_o,
    output logic glitch_o
);
    logic s1_r, s2_r;
    logic [3:0] cnt_r;

    // Two-flop synchroniser; only s2_r is looked at
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= pin_b_i;
            s2_r <= s1_r;
        end
    end

    // Count low cycles; shorter pulses only raise a glitch event
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !enable_i) begin
            cnt_r <= 4'h0;
            req_o <= 1'b0;
            glitch_o <= 1'b0;
        end else if (!s2_r) begin
            if (cnt_r < 4'(MIN_CYCLES)) cnt_r <= cnt_r + 4'h1;
            req_o <= (cnt_r >= 4'(MIN_CYCLES - 1));
            glitch_o <= 1'b0;
        end else begin
            cnt_r <= 4'h0;
            req_o <= 1'b0;
            glitch_o <= (cnt_r != 4'h0) && (cnt_r < 4'(MIN_CYCLES));
        end
    end
endmodule // srs_pin_filter

/* verilog/srs_por_counter.sv */
// Power-on delay counter with short and long timeouts
`timescale 1ns/1ps
module srs_por_counter #(
    parameter int SHORT_CYCLES = srs_pkg::SRS_POR_CYCLES,
    parameter int LONG_CYCLES = srs_pkg::SRS_POR_XTAL_CYCLES,
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic run_i,
    input wire logic long_i,
    // Timeout reached, level while run_i stays high
    output logic done_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] limit;

    // Crystal start-up needs the longer wait
    assign limit = long_i ? W'(LONG_CYCLES - 1) : W'(SHORT_CYCLES - 1);

    // Restart whenever run_i drops, so a dip restarts the full delay
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !run_i) begin
            cnt_r <= '0;
            done_o <= 1'b0;
        end else if (!done_o) begin
            cnt_r <= cnt_r + W'(1);
            done_o <= (cnt_r >= limit);
        end
    end
endmodule // srs_por_counter

/* verilog/srs_sequencer.sv */
// System reset sequencer: source collection, delay, release, status
//
// Summary of operation
// - Ignore reset pin pulses under three clocks.
// - Watchdog timeout in reset mode resets system.
// - Debugger control bit resets all but debugger.
// - STOP mode uses analog-filtered reset pin.
// - Power-on delay starts after supply above threshold.
// - Hold reset until power-on counter expires.
// - Crystal enabled selects longer power-on timeout.
// - Release lets processor fetch reset vector first.
// - Power-on sets power-on cause flag.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module srs_sequencer
    import srs_pkg::*;
#(
    parameter int POR_CYCLES = srs_pkg::SRS_POR_CYCLES,
    parameter int POR_XTAL_CYCLES = srs_pkg::SRS_POR_XTAL_CYCLES,
    parameter int SYS_CYCLES = srs_pkg::SRS_SYS_RST_CYCLES
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Supply monitor
    input wire logic SUPPLY_OK_I,
    input wire logic BROWNOUT_I,
    // Reset sources
    input wire logic WDT_TIMEOUT_I,
    input wire logic RESET_PIN_B_I,
    input wire logic STOP_PIN_FILT_B_I,
    input wire logic DEBUG_PIN_B_I,
    // Operating mode and option bits
    input wire logic STOP_MODE_I,
    input wire logic XTAL_EN_I,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Reset and interrupt outputs
    output logic SYS_RST_B_O,
    output logic DEBUG_UNIT_RST_B_O,
    output logic FETCH_VECTOR_O,
    output logic IRQ_O
);
    srs_state_type state_r, state_nxt;

    logic pin_req, pin_glitch, por_done;
    logic stop_s1_r, stop_s2_r, dpin_s1_r, dpin_s2_r;
    logic [7:0] debugger_control_reg_r;
    logic [7:0] cfg_r;
    logic [7:0] reset_cause_reg_r, cause_set;
    logic [7:0] irq_stat_r, irq_mask_r, irq_set;
    logic [7:0] sys_cnt_r;
    logic supply_good;
    logic wdt_rst, wdt_irq, dbg_req, stop_pin_req, dbg_pin_req;
    logic any_src;
    logic wr_dbgctl, wr_cfg, wr_cause, wr_stat, wr_mask;

    // Supply must be above threshold and free of brownout
    assign supply_good = SUPPLY_OK_I && !BROWNOUT_I;

    // Watchdog steers to reset or to interrupt by configuration
    assign wdt_rst = WDT_TIMEOUT_I && cfg_r[SRS_CFG_WDT_RST_BIT];
    assign wdt_irq = WDT_TIMEOUT_I && !cfg_r[SRS_CFG_WDT_RST_BIT];

    // Debugger request bit stays set until the reset is taken
    assign dbg_req = debugger_control_reg_r[SRS_DBGCTL_RST_BIT];

    // STOP-mode sources come from the analog filter and the debug pin
    assign stop_pin_req = STOP_MODE_I && !stop_s2_r;
    assign dbg_pin_req = STOP_MODE_I && !dpin_s2_r;

    // Any non-power source that asks for a system reset
    assign any_src = wdt_rst || pin_req || dbg_req || stop_pin_req || dbg_pin_req;

    // Register write decode
    assign wr_dbgctl = WR_I && (ADDR_I == SRS_ADDR_DBGCTL);
    assign wr_cfg = WR_I && (ADDR_I == SRS_ADDR_CFG);
    assign wr_cause = WR_I && (ADDR_I == SRS_ADDR_CAUSE);
    assign wr_stat = WR_I && (ADDR_I == SRS_ADDR_IRQ_STAT);
    assign wr_mask = WR_I && (ADDR_I == SRS_ADDR_IRQ_MASK);

    // Digital filter on the pin, active outside STOP mode
    srs_pin_filter #(
        .MIN_CYCLES(SRS_PIN_MIN_CYCLES)
    ) u_pin_filter (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .pin_b_i(RESET_PIN_B_I),
        .enable_i(!STOP_MODE_I),
        .req_o(pin_req),
        .glitch_o(pin_glitch)
    );

    // Power-on delay counter runs only in the power-on state
    srs_por_counter #(
        .SHORT_CYCLES(POR_CYCLES),
        .LONG_CYCLES(POR_XTAL_CYCLES),
        .W(24)
    ) u_por_counter (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .run_i(state_r == SRS_ST_POR && supply_good),
        .long_i(XTAL_EN_I),
        .done_o(por_done)
    );

    // Synchronisers for the STOP-mode pins
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            stop_s1_r <= 1'b1;
            stop_s2_r <= 1'b1;
            dpin_s1_r <= 1'b1;
            dpin_s2_r <= 1'b1;
        end else begin
            stop_s1_r <= STOP_PIN_FILT_B_I;
            stop_s2_r <= stop_s1_r;
            dpin_s1_r <= DEBUG_PIN_B_I;
            dpin_s2_r <= dpin_s1_r;
        end
    end

    // Next-state logic; supply loss always wins over other sources
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SRS_ST_HOLD: begin
                if (supply_good) state_nxt = SRS_ST_POR;
            end
            SRS_ST_POR: begin
                if (!supply_good) state_nxt = SRS_ST_HOLD;
                else if (por_done) state_nxt = SRS_ST_RUN;
            end
            SRS_ST_SYS: begin
                if (!supply_good) state_nxt = SRS_ST_HOLD;
                else if (sys_cnt_r == 8'h00 && !any_src) state_nxt = SRS_ST_RUN;
            end
            SRS_ST_RUN: begin
                if (!supply_good) state_nxt = SRS_ST_HOLD;
                else if (any_src) state_nxt = SRS_ST_SYS;
            end
            default: state_nxt = SRS_ST_HOLD;
        endcase
    end

    // State register
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) state_r <= SRS_ST_HOLD;
        else state_r <= state_nxt;
    end

    // Minimum system reset width; reloads while a source persists
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sys_cnt_r <= 8'h00;
        end else if (state_nxt == SRS_ST_SYS && (state_r != SRS_ST_SYS || any_src)) begin
            sys_cnt_r <= 8'(SYS_CYCLES - 1);
        end else if (sys_cnt_r != 8'h00) begin
            sys_cnt_r <= sys_cnt_r - 8'h01;
        end
    end

    // Reset outputs, all registered and released on a clock edge
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            SYS_RST_B_O <= 1'b0;
            DEBUG_UNIT_RST_B_O <= 1'b0;
            FETCH_VECTOR_O <= 1'b0;
        end else begin
            SYS_RST_B_O <= (state_nxt == SRS_ST_RUN);
            // Debug unit only sees power-type resets
            DEBUG_UNIT_RST_B_O <= (state_nxt == SRS_ST_SYS) ||
                                  (state_nxt == SRS_ST_RUN);
            FETCH_VECTOR_O <= (state_nxt == SRS_ST_RUN) &&
                              (state_r != SRS_ST_RUN);
        end
    end

    // Debugger control register survives system resets by design
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            debugger_control_reg_r <= SRS_ZERO;
        end else if (state_r == SRS_ST_HOLD) begin
            debugger_control_reg_r <= SRS_ZERO;
        end else if (wr_dbgctl) begin
            debugger_control_reg_r <= WDATA_I;
        end else if (state_r == SRS_ST_SYS && dbg_req) begin
            // Request consumed once the reset is under way
            debugger_control_reg_r[SRS_DBGCTL_RST_BIT] <= 1'b0;
        end
    end

    // Configuration register
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) cfg_r <= SRS_CFG_RST;
        else if (wr_cfg) cfg_r <= WDATA_I;
    end

    // Cause bits latched as each reset is entered, the power-on bit when its delay ends
    always_comb begin
        cause_set = SRS_ZERO;
        cause_set[SRS_CAUSE_POR_BIT] = (state_r == SRS_ST_POR) && (state_nxt == SRS_ST_RUN);
        cause_set[SRS_CAUSE_BO_BIT] = (state_r != SRS_ST_HOLD) && (state_nxt == SRS_ST_HOLD);
        if (state_r == SRS_ST_RUN && state_nxt == SRS_ST_SYS) begin
            cause_set[SRS_CAUSE_WDT_BIT] = wdt_rst;
            cause_set[SRS_CAUSE_PIN_BIT] = pin_req;
            cause_set[SRS_CAUSE_DBGREQ_BIT] = dbg_req;
            cause_set[SRS_CAUSE_STOPPIN_BIT] = stop_pin_req;
            cause_set[SRS_CAUSE_DBGPIN_BIT] = dbg_pin_req;
        end
    end

    // Reset cause register: write one to clear, a new cause wins
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            reset_cause_reg_r <= SRS_ZERO;
        end else begin
            reset_cause_reg_r <= (reset_cause_reg_r & ~(wr_cause ? WDATA_I : SRS_ZERO))
                                 | cause_set;
        end
    end

    // Interrupt events
    always_comb begin
        irq_set = SRS_ZERO;
        irq_set[SRS_IRQ_WDT_BIT] = wdt_irq && (state_r == SRS_ST_RUN);
        irq_set[SRS_IRQ_GLITCH_BIT] = pin_glitch;
        irq_set[SRS_IRQ_RELEASE_BIT] = (state_nxt == SRS_ST_RUN) && (state_r != SRS_ST_RUN);
    end

    // Sticky status, set wins over a write-one clear
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            irq_stat_r <= SRS_ZERO;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? WDATA_I : SRS_ZERO)) | irq_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) irq_mask_r <= SRS_MASK_RST;
        else if (wr_mask) irq_mask_r <= WDATA_I;
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) IRQ_O <= 1'b0;
        else IRQ_O <= |(irq_stat_r & irq_mask_r);
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || !RD_I) begin
            RDATA_O <= SRS_ZERO;
        end else begin
            unique case (ADDR_I)
                SRS_ADDR_DBGCTL: RDATA_O <= debugger_control_reg_r;
                SRS_ADDR_CFG: RDATA_O <= cfg_r;
                SRS_ADDR_CAUSE: RDATA_O <= reset_cause_reg_r;
                SRS_ADDR_IRQ_STAT: RDATA_O <= irq_stat_r;
                SRS_ADDR_IRQ_MASK: RDATA_O <= irq_mask_r;
                default: RDATA_O <= SRS_ZERO;
            endcase
        end
    end
endmodule // srs_sequencer

/* dv/srs_sequencer_asserts.sv */
// Port-level checker of the reset sequencer, bound to its top module
`timescale 1ns/1ps
module srs_sequencer_chk
    import srs_pkg::*;
#(
    parameter int POR_CYCLES = SRS_POR_CYCLES,
    parameter int POR_XTAL_CYCLES = SRS_POR_XTAL_CYCLES
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Watched inputs
    input wire logic SUPPLY_OK_I,
    input wire logic BROWNOUT_I,
    input wire logic RESET_PIN_B_I,
    input wire logic STOP_MODE_I,
    input wire logic XTAL_EN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    // Watched outputs
    input wire logic SYS_RST_B_O,
    input wire logic DEBUG_UNIT_RST_B_O,
    input wire logic FETCH_VECTOR_O
);
    int good_r;
    int low_r;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Good-supply cycles; cleared with reset so it never runs ahead of the block
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || !SUPPLY_OK_I || BROWNOUT_I) begin
            good_r <= 0;
        end else begin
            good_r <= good_r + 1;
        end
    end
    // Length of the present low run on the reset pin
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || RESET_PIN_B_I) begin
            low_r <= 0;
        end else begin
            low_r <= low_r + 1;
        end
    end
    supply_hold_a: assert property ((!SUPPLY_OK_I || BROWNOUT_I)
        |=> (!SYS_RST_B_O && !DEBUG_UNIT_RST_B_O)) else $error("reset not held on low supply");
    por_min_a: assert property ($rose(DEBUG_UNIT_RST_B_O)
        |-> good_r >= (XTAL_EN_I ? POR_XTAL_CYCLES : POR_CYCLES)) else $error("power-on too short");
    por_max_a: assert property ($rose(DEBUG_UNIT_RST_B_O)
        |-> good_r <= (XTAL_EN_I ? POR_XTAL_CYCLES : POR_CYCLES) + 6) else $error("power-on too long");
    fetch_rise_a: assert property (FETCH_VECTOR_O == $rose(SYS_RST_B_O))
        else $error("fetch pulse not on release");
    rel_both_a: assert property ($rose(DEBUG_UNIT_RST_B_O) |-> $rose(SYS_RST_B_O))
        else $error("power-on release not joint");
    sys_min_a: assert property ($fell(SYS_RST_B_O) |=> !SYS_RST_B_O [*8])
        else $error("system reset too short");
    dbg_req_a: assert property ((WR_I && ADDR_I == SRS_ADDR_DBGCTL && WDATA_I[0]
        && SYS_RST_B_O) |-> ##2 (!SYS_RST_B_O && DEBUG_UNIT_RST_B_O))
        else $error("debugger reset wrong");
    pin_short_a: assert property (($rose(RESET_PIN_B_I) && low_r < SRS_PIN_MIN_CYCLES
        && !STOP_MODE_I && SYS_RST_B_O) |-> SYS_RST_B_O [*8]) else $error("short pulse reset");
    // Main scenarios reached
    cover property ($rose(DEBUG_UNIT_RST_B_O));
    cover property ($fell(SYS_RST_B_O) && DEBUG_UNIT_RST_B_O);
    cover property ($rose(RESET_PIN_B_I) && low_r < SRS_PIN_MIN_CYCLES);
endmodule // srs_sequencer_chk

bind srs_sequencer srs_sequencer_chk #(
    .POR_CYCLES(POR_CYCLES),
    .POR_XTAL_CYCLES(POR_XTAL_CYCLES)
) u_chk (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SUPPLY_OK_I(SUPPLY_OK_I), .BROWNOUT_I(BROWNOUT_I),
    .RESET_PIN_B_I(RESET_PIN_B_I), .STOP_MODE_I(STOP_MODE_I), .XTAL_EN_I(XTAL_EN_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .SYS_RST_B_O(SYS_RST_B_O),
    .DEBUG_UNIT_RST_B_O(DEBUG_UNIT_RST_B_O), .FETCH_VECTOR_O(FETCH_VECTOR_O)
);

/* dv/srs_pin_driver.sv */
// Behavioural driver of the external reset pin
`timescale 1ns/1ps
module srs_pin_driver (
    // Clock
    input wire logic clk_i,
    // Pulse request and width in clocks
    input wire logic start_i,
    input wire logic [7:0] len_i,
    // Pin, pulled up while released
    output logic pin_b_o
);
    int left_r = 0;
    logic pin_r = 1'b1;
    assign pin_b_o = pin_r;
    // Low for exactly len_i sampled edges, so widths at the limit are exact
    always @(posedge clk_i) begin
        if (start_i) begin
            pin_r <= 1'b0;
            left_r <= len_i - 1;
        end else if (left_r != 0) begin
            left_r <= left_r - 1;
        end else begin
            pin_r <= 1'b1;
        end
    end
endmodule // srs_pin_driver

/* dv/test_srs_sequencer.sv */
// Self-checking bench of the system reset sequencer
`timescale 1ns/1ps
module test_srs_sequencer;
    import srs_pkg::*;
    // Short power-on counts keep the run brief
    localparam int NP = 20;
    localparam int NX = 60;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sup = 1'b0;
    logic bo = 1'b0;
    logic wdt = 1'b0;
    logic stp_b = 1'b1;
    logic dpin_b = 1'b1;
    logic stop = 1'b0;
    logic xtal = 1'b0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic start = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] plen = 8'h00;
    logic [7:0] rdata;
    logic pin_b, sys_b, dbg_b, fetch, irq;
    int fails = 0;
    int comparisons = 0;
    int tick = 0;

    always #2 clk = ~clk;

    srs_pin_driver u_pin (.clk_i(clk), .start_i(start), .len_i(plen), .pin_b_o(pin_b));

    srs_sequencer #(.POR_CYCLES(NP), .POR_XTAL_CYCLES(NX)) dut (
        .CLK_I(clk), .RST_B_I(rst_b), .SUPPLY_OK_I(sup), .BROWNOUT_I(bo),
        .WDT_TIMEOUT_I(wdt), .RESET_PIN_B_I(pin_b), .STOP_PIN_FILT_B_I(stp_b),
        .DEBUG_PIN_B_I(dpin_b), .STOP_MODE_I(stop), .XTAL_EN_I(xtal), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SYS_RST_B_O(sys_b),
        .DEBUG_UNIT_RST_B_O(dbg_b), .FETCH_VECTOR_O(fetch), .IRQ_O(irq)
    );

    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; a hang ends here
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 5000) begin
            fails = fails + 1;
            report_and_stop;
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_up(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n = n + 1;
        end while (sys_b !== 1'b1 && n < 300);
    endtask

    // System reset from a running state: debug unit kept, vector fetch, cause bit
    task automatic expect_rst(input int b);
        int n;
        logic [7:0] d;
        // Look after the launching edge has settled the reset output
        #1 n = 0;
        while (sys_b !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1 n = n + 1;
        end
        chk("sys_low", 0, sys_b);
        chk("dbg_kept", 1, dbg_b);
        wait_up(n);
        chk("fetch", 1, fetch);
        rd(SRS_ADDR_CAUSE, d);
        chk("cause", 1, d[b]);
        wr(SRS_ADDR_CAUSE, 8'hFF);
    endtask

    task automatic t_power(input logic x, input int lim);
        int n;
        logic [7:0] d;
        @(posedge clk);
        xtal <= x;
        sup <= 1'b1;
        bo <= 1'b0;
        wait_up(n);
        chk("por_min", 1, n >= lim);
        chk("por_max", 1, n <= lim + 6);
        chk("fetch_por", 1, fetch);
        chk("dbg_rel", 1, dbg_b);
        rd(SRS_ADDR_CAUSE, d);
        chk("cause_por", 1, d[SRS_CAUSE_POR_BIT]);
        wr(SRS_ADDR_CAUSE, 8'hFF);
    endtask

    task automatic t_wdt;
        logic [7:0] d;
        rd(SRS_ADDR_CFG, d);
        chk("cfg_rst", SRS_CFG_RST, d);
        rd(SRS_ADDR_IRQ_MASK, d);
        chk("mask_rst", SRS_MASK_RST, d);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            wdt <= 1'b1;
            @(posedge clk);
            wdt <= 1'b0;
            if (i == 0) begin
                expect_rst(SRS_CAUSE_WDT_BIT);
                wr(SRS_ADDR_CFG, 8'h00);
                wr(SRS_ADDR_IRQ_MASK, 8'h01);
                wr(SRS_ADDR_IRQ_STAT, 8'hFF);
            end
        end
        cyc(3);
        #1 chk("wdt_irq_mode", 1, sys_b);
        chk("irq_up", 1, irq);
        wr(SRS_ADDR_IRQ_MASK, 8'h00);
        cyc(2);
        #1 chk("irq_masked", 0, irq);
        wr(SRS_ADDR_IRQ_MASK, 8'h01);
        cyc(2);
        #1 chk("irq_sticky", 1, irq);
        wr(SRS_ADDR_IRQ_STAT, 8'h01);
        cyc(2);
        #1 chk("irq_clear", 0, irq);
        wr(SRS_ADDR_CFG, 8'h01);
    endtask

    task automatic t_pin;
        logic [7:0] d;
        wr(SRS_ADDR_IRQ_STAT, 8'hFF);
        for (int w = 2; w <= 3; w++) begin
            @(posedge clk);
            start <= 1'b1;
            plen <= 8'(w);
            @(posedge clk);
            start <= 1'b0;
            // Let the pin return high so the two pulses stay apart
            cyc(8);
        end
        // The second, wider pulse follows the glitch and must reset
        expect_rst(SRS_CAUSE_PIN_BIT);
        rd(SRS_ADDR_IRQ_STAT, d);
        chk("glitch_flag", 1, d[SRS_IRQ_GLITCH_BIT]);
        rd(4'hF, d);
        chk("unmapped", 0, d);
    endtask

    task automatic t_stop;
        @(posedge clk);
        stp_b <= 1'b0;
        cyc(8);
        #1 chk("stop_pin_idle", 1, sys_b);
        @(posedge clk);
        stop <= 1'b1;
        cyc(4);
        stp_b <= 1'b1;
        expect_rst(SRS_CAUSE_STOPPIN_BIT);
        @(posedge clk);
        dpin_b <= 1'b0;
        cyc(4);
        dpin_b <= 1'b1;
        expect_rst(SRS_CAUSE_DBGPIN_BIT);
        stop <= 1'b0;
    endtask

    initial begin
        cyc(6);
        rst_b <= 1'b1;
        cyc(30);
        #1 chk("hold_sys", 0, sys_b);
        chk("hold_dbg", 0, dbg_b);
        t_power(1'b0, NP);
        @(posedge clk);
        bo <= 1'b1;
        cyc(3);
        #1 chk("bo_sys", 0, sys_b);
        chk("bo_dbg", 0, dbg_b);
        t_power(1'b1, NX);
        wr(SRS_ADDR_DBGCTL, 8'h01);
        expect_rst(SRS_CAUSE_DBGREQ_BIT);
        t_wdt;
        t_pin;
        t_stop;
        report_and_stop;
    end
endmodule // test_srs_sequencer
